//--- src/rtc_port_regs.svh
// constants for the two-wire register port: address, bit counts, reset values
// assumes the including file needs no other definitions
`ifndef RTC_PORT_REGS_SVH
`define RTC_PORT_REGS_SVH

// fixed 7-bit slave address, acknowledged only on exact match
`define SLAVE_ADDR 7'h69
// width of a transferred byte and of the register pointer
`define BYTE_W 8
// bit counter value once all eight bits of a received byte are in
`define RX_BITS 4'h8
// bit counter value while the last bit of a sent byte is on the line
`define TX_LAST_BIT 4'h7
// register pointer value after reset
`define PTR_RESET 8'h00
// equal samples, besides the current one, needed before a line level is believed
`define STABLE_SAMPLES 2
// core clock period and shortest high phase of the bus clock
`define CORE_PERIOD_NS 4
`define SCL_HIGH_MIN_NS 600
`define SCL_HIGH_MIN_CYC ((`SCL_HIGH_MIN_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

`endif

//--- src/rtc_port_pkg.sv
// types used by the two-wire register port module rtc_i2c_slave_port
// assumes nothing of its surroundings
package rtc_port_pkg;

  // bit-level protocol position of the slave
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_RX_BYTE,
    ST_RX_ACK,
    ST_TX_BYTE,
    ST_TX_ACK,
    ST_IGNORE
  } port_state_t;

  // meaning of the byte being received
  typedef enum logic [1:0]
  {
    K_ADDR,
    K_OFFSET,
    K_DATA
  } byte_kind_t;

endpackage

//--- src/line_evt_if.sv
// filtered level and edge pulses of one bus line, core clock domain
// assumes a single producer and any number of readers
`timescale 1ns/100ps
interface line_evt_if;
  logic level;
  logic rise;
  logic fall;

  modport src
  (
    output level,
    output rise,
    output fall
  );

  modport dst
  (
    input level,
    input rise,
    input fall
  );
endinterface

//--- src/line_filter.sv
// synchroniser, glitch filter and edge detector for one bus line
// assumes the raw line is asynchronous to core_clk and idles high
`timescale 1ns/100ps
`include "rtc_port_regs.svh"
module line_filter #(
  parameter int STABLE = `STABLE_SAMPLES
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic raw,
  line_evt_if.src evt
);

  logic meta;
  logic sync;
  logic [STABLE-1:0] hist;

  // two flip-flops before anything looks at the line
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      meta <= 1'b1;
      sync <= 1'b1;
    end
    else
    begin
      meta <= raw;
      sync <= meta;
    end
  end

  // a level is believed only after STABLE+1 equal samples, so one-sample spikes vanish
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      hist <= '1;
      evt.level <= 1'b1;
      evt.rise <= 1'b0;
      evt.fall <= 1'b0;
    end
    else
    begin
      hist <= {hist[STABLE-2:0], sync};
      evt.rise <= 1'b0;
      evt.fall <= 1'b0;
      if (&{hist, sync} && !evt.level) // R22
      begin
        evt.level <= 1'b1;
        evt.rise <= 1'b1;
      end
      else if (!(|{hist, sync}) && evt.level) // R22
      begin
        evt.level <= 1'b0;
        evt.fall <= 1'b1;
      end
    end
  end

endmodule

//--- src/rtc_i2c_slave_port.sv
// two-wire serial slave giving a bus master byte access to offset-mapped registers
// assumes an external register file that answers reg_rdata combinationally from reg_addr
//
// Contract
// R1: acknowledge only the fixed slave address
// R2: seven address bits MSB first, then direction
// R3: start is data falling while clock high
// R4: stop is data rising while clock high
// R5: repeated start acts as stop plus start
// R6: bus idle while both lines high
// R7: master starts transfers only on idle bus
// R8: data changes only while clock is low
// R9: eight data bits then one acknowledge bit
// R10: unlimited data bytes per transaction
// R11: acknowledge low stable over clock high
// R12: acknowledge every byte when addressed receiver
// R13: master acknowledges all read bytes but last
// R14: on master nak release line, stop sending
// R15: first write byte loads the register pointer
// R16: later write bytes store, then pointer increments
// R17: read sends pointed register, then pointer increments
// R18: read burst ends on nak, stop, restart
// R19: pointer kept across transactions
// R20: master writes offset, then addresses for read
// R21: works at bus clock up to fast mode
// R22: synchronise and filter lines before decoding
`timescale 1ns/100ps
`include "rtc_port_regs.svh"
module rtc_i2c_slave_port #(
  parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [`BYTE_W-1:0] reg_addr,
  output logic [`BYTE_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [`BYTE_W-1:0] reg_rdata,
  output logic busy
);

  // ==========================================================
  // line conditioning
  line_evt_if scl ();
  line_evt_if sda ();

  // both lines see the same latency, so start and stop keep their ordering
  line_filter u_scl_filter
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .raw(scl_in), // R21
    .evt(scl.src)
  );

  line_filter u_sda_filter
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .raw(sda_in),
    .evt(sda.src)
  );

  // ==========================================================
  // bus conditions
  logic start_ev;
  logic stop_ev;
  logic bus_idle;
  logic rx_done;

  assign start_ev = sda.fall && scl.level; // R3
  assign stop_ev = sda.rise && scl.level; // R4
  assign bus_idle = sda.level && scl.level; // R6

  // ==========================================================
  // protocol state
  rtc_port_pkg::port_state_t state;
  rtc_port_pkg::byte_kind_t kind;
  logic [3:0] bit_cnt;
  logic [`BYTE_W-1:0] shift;
  logic [`BYTE_W-1:0] pointer;
  logic rw_read;
  logic acked;

  // last received bit is in and the clock has dropped: time to answer
  assign rx_done = state == rtc_port_pkg::ST_RX_BYTE && scl.fall && bit_cnt == `RX_BITS; // R9

  // main sequencer; start and stop override whatever the bit engine does
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state <= rtc_port_pkg::ST_IDLE;
      kind <= rtc_port_pkg::K_ADDR;
      bit_cnt <= 4'h0;
      rw_read <= 1'b0;
      acked <= 1'b0;
    end
    else if (start_ev)
    begin
      // a restart simply re-enters address reception, like stop then start
      state <= rtc_port_pkg::ST_RX_BYTE; // R3 R5
      kind <= rtc_port_pkg::K_ADDR;
      bit_cnt <= 4'h0;
    end
    else if (stop_ev)
    begin
      state <= rtc_port_pkg::ST_IDLE; // R4 R18
      bit_cnt <= 4'h0;
    end
    else
    begin
      unique case (state)
        rtc_port_pkg::ST_IDLE,
        rtc_port_pkg::ST_IGNORE:
        begin
          bit_cnt <= 4'h0;
        end
        rtc_port_pkg::ST_RX_BYTE:
        begin
          if (scl.rise)
          begin
            bit_cnt <= bit_cnt + 4'h1; // R8
          end
          if (rx_done)
          begin
            if (kind == rtc_port_pkg::K_ADDR && shift[7:1] != SLAVE_ADDR)
            begin
              state <= rtc_port_pkg::ST_IGNORE; // R1
            end
            else
            begin
              state <= rtc_port_pkg::ST_RX_ACK; // R12
            end
            if (kind == rtc_port_pkg::K_ADDR)
            begin
              rw_read <= shift[0]; // R2
            end
          end
        end
        rtc_port_pkg::ST_RX_ACK:
        begin
          // acknowledge pulse over: decide what the next byte is
          if (scl.fall)
          begin
            bit_cnt <= 4'h0;
            if (kind == rtc_port_pkg::K_ADDR && rw_read)
            begin
              state <= rtc_port_pkg::ST_TX_BYTE; // R17
            end
            else
            begin
              state <= rtc_port_pkg::ST_RX_BYTE; // R10
              kind <= (kind == rtc_port_pkg::K_ADDR) ? rtc_port_pkg::K_OFFSET
                                                     : rtc_port_pkg::K_DATA;
            end
          end
        end
        rtc_port_pkg::ST_TX_BYTE:
        begin
          if (scl.fall)
          begin
            if (bit_cnt == `TX_LAST_BIT)
            begin
              state <= rtc_port_pkg::ST_TX_ACK; // R9
              bit_cnt <= 4'h0;
            end
            else
            begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        rtc_port_pkg::ST_TX_ACK:
        begin
          if (scl.rise)
          begin
            acked <= !sda.level; // R13
          end
          if (scl.fall)
          begin
            // a nak ends the burst; stay off the line until the next condition
            state <= acked ? rtc_port_pkg::ST_TX_BYTE : rtc_port_pkg::ST_IGNORE; // R14 R18
          end
        end
      endcase
    end
  end

  // ==========================================================
  // data shifter; a read loads one cycle after reg_rd, while the clock is low
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      shift <= 8'h00;
    end
    else if (reg_rd)
    begin
      shift <= reg_rdata; // R17
    end
    else if (state == rtc_port_pkg::ST_RX_BYTE && scl.rise)
    begin
      shift <= {shift[6:0], sda.level}; // R2
    end
    else if (state == rtc_port_pkg::ST_TX_BYTE && scl.fall && bit_cnt != `TX_LAST_BIT)
    begin
      shift <= {shift[6:0], 1'b0}; // R8
    end
  end

  // ==========================================================
  // register pointer and register-side strobes
  // the pointer is never cleared by bus conditions, so a bare read resumes
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pointer <= `PTR_RESET;
      reg_addr <= `PTR_RESET;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
    else
    begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (rx_done && kind == rtc_port_pkg::K_OFFSET)
      begin
        pointer <= shift; // R15 R19
      end
      else if (rx_done && kind == rtc_port_pkg::K_DATA)
      begin
        reg_addr <= pointer; // R16
        reg_wdata <= shift;
        reg_wr <= 1'b1;
        pointer <= pointer + 8'h01; // R16
      end
      else if (!start_ev && !stop_ev && scl.fall
               && ((state == rtc_port_pkg::ST_RX_ACK && kind == rtc_port_pkg::K_ADDR && rw_read)
                   || (state == rtc_port_pkg::ST_TX_ACK && acked)))
      begin
        reg_addr <= pointer; // R17
        reg_rd <= 1'b1;
        pointer <= pointer + 8'h01; // R17
      end
    end
  end

  // ==========================================================
  // open-drain data line: only ever pulled low, released otherwise
  // updating after the filtered clock fall keeps changes inside the low phase
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sda_oe <= 1'b0;
    end
    else if (start_ev || stop_ev)
    begin
      sda_oe <= 1'b0; // R4
    end
    else
    begin
      sda_oe <= (state == rtc_port_pkg::ST_RX_ACK) // R11
                || (state == rtc_port_pkg::ST_TX_BYTE && !reg_rd && !shift[7]); // R8
    end
  end

  assign sda_out = 1'b0;
  assign busy = state != rtc_port_pkg::ST_IDLE && state != rtc_port_pkg::ST_IGNORE;

  // ==========================================================
  // checks
  // every answer lands a few cycles after a filtered clock edge, which keeps
  // it well inside the shortest fast-mode low phase
  logic quiet_ok;
  assign quiet_ok = !scl.level || start_ev || stop_ev;

  sequence s_addr_match;
    rx_done && kind == rtc_port_pkg::K_ADDR && shift[7:1] == SLAVE_ADDR;
  endsequence

  sequence s_addr_miss;
    rx_done && kind == rtc_port_pkg::K_ADDR && shift[7:1] != SLAVE_ADDR;
  endsequence

  sequence s_tx_nak;
    state == rtc_port_pkg::ST_TX_ACK && scl.fall && !acked && !start_ev && !stop_ev;
  endsequence

  property p_addr_ack;
    @(posedge core_clk) disable iff (!rst_b)
    s_addr_match |=> state == rtc_port_pkg::ST_RX_ACK ##1 sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) // R1
    else $error("matching address not acknowledged");

  property p_addr_silent;
    @(posedge core_clk) disable iff (!rst_b)
    s_addr_miss |=> (!sda_oe && state == rtc_port_pkg::ST_IGNORE) [*4];
  endproperty
  a_addr_silent: assert property (p_addr_silent) // R1
    else $error("foreign address drew a response");

  property p_start;
    @(posedge core_clk) disable iff (!rst_b)
    start_ev |=> state == rtc_port_pkg::ST_RX_BYTE && kind == rtc_port_pkg::K_ADDR
                 && bit_cnt == 4'h0;
  endproperty
  a_start: assert property (p_start) // R3
    else $error("start did not restart address reception");

  property p_stop;
    @(posedge core_clk) disable iff (!rst_b)
    stop_ev |=> state == rtc_port_pkg::ST_IDLE ##1 !sda_oe;
  endproperty
  a_stop: assert property (p_stop) // R4
    else $error("stop did not end the transaction");

  property p_data_ack;
    @(posedge core_clk) disable iff (!rst_b)
    (rx_done && kind != rtc_port_pkg::K_ADDR) |=> ##1 sda_oe;
  endproperty
  a_data_ack: assert property (p_data_ack) // R12
    else $error("received byte not acknowledged");

  property p_offset_load;
    @(posedge core_clk) disable iff (!rst_b)
    (rx_done && kind == rtc_port_pkg::K_OFFSET) |=> pointer == $past(shift) && !reg_wr;
  endproperty
  a_offset_load: assert property (p_offset_load) // R15
    else $error("offset byte not loaded into pointer");

  property p_write_step;
    @(posedge core_clk) disable iff (!rst_b)
    reg_wr |-> pointer == reg_addr + 8'h01 && reg_wdata == $past(shift);
  endproperty
  a_write_step: assert property (p_write_step) // R16
    else $error("write did not advance the pointer");

  property p_read_step;
    @(posedge core_clk) disable iff (!rst_b)
    reg_rd |-> pointer == reg_addr + 8'h01 && state == rtc_port_pkg::ST_TX_BYTE
               ##1 shift == $past(reg_rdata);
  endproperty
  a_read_step: assert property (p_read_step) // R17
    else $error("read byte not loaded or pointer not advanced");

  property p_nak_release;
    @(posedge core_clk) disable iff (!rst_b)
    s_tx_nak |=> (!sda_oe && !reg_rd) [*8];
  endproperty
  a_nak_release: assert property (p_nak_release) // R14
    else $error("line still driven after master nak");

  property p_ack_hold;
    @(posedge core_clk) disable iff (!rst_b)
    (state == rtc_port_pkg::ST_RX_ACK && scl.level) |-> sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) // R11
    else $error("acknowledge released during clock high");

  property p_change_low;
    @(posedge core_clk) disable iff (!rst_b)
    $changed(sda_oe) |-> $past(quiet_ok);
  endproperty
  a_change_low: assert property (p_change_low) // R8
    else $error("data line changed while clock high");

  property p_idle_quiet;
    @(posedge core_clk) disable iff (!rst_b)
    (bus_idle && state == rtc_port_pkg::ST_IDLE) |=> !sda_oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // R6
    else $error("line driven on an idle bus");

endmodule

//--- bench/i2c_master_model.sv
// bus master model for the two-wire slave port: start, stop, byte write and byte read
// assumes the data wire is resolved outside and reads high when nobody pulls it low
`timescale 1ns/100ps
module i2c_master_model
(
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // ==========================================================
  // line timing
  // both lines released: the bus is idle until a start
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // a quarter bit is five core cycles, so one bit lasts 80 ns
  task automatic quarter();
    repeat (5) @(posedge core_clk);
    #1;
  endtask

  // ==========================================================
  // bus conditions
  // data released while the clock is low, so a restart is no false stop
  task automatic start();
    sda_pull = 1'b0;
    quarter();
    scl = 1'b1;
    quarter();
    quarter();
    sda_pull = 1'b1;
    quarter();
    quarter();
    scl = 1'b0;
    quarter();
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    quarter();
    sda_pull = 1'b0;
    quarter();
    quarter();
  endtask

  // ==========================================================
  // bits and bytes
  // data set in the low phase, read in the middle of the high phase
  task automatic bit_xfer(input logic b, output logic r);
    sda_pull = ~b;
    quarter();
    scl = 1'b1;
    quarter();
    r = sda_line;
    quarter();
    scl = 1'b0;
    quarter();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // the caller leaves the last byte unacknowledged
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      bit_xfer(1'b1, r);
      d = {d[6:0], r};
    end
    bit_xfer(~mack, r);
  endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench for the two-wire register port with a master model
// assumes the register file behind the port answers reads combinationally
`timescale 1ns/100ps
module tb_top;
  logic core_clk;
  logic rst_b;
  logic scl;
  logic sda_pull;
  logic sda_line;
  logic sda_out;
  logic sda_oe;
  logic reg_wr;
  logic reg_rd;
  logic busy;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] mem [256];
  int n_mismatch;
  int checks;
  int cycles;

  // ==========================================================
  // clock, wire and register file
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // open drain: low while either party pulls, else the pull-up wins
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_out));
  assign reg_rdata = mem[reg_addr];

  always @(posedge core_clk)
  begin
    if (reg_wr === 1'b1)
      mem[reg_addr] <= reg_wdata;
  end

  i2c_master_model m_u (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
    .sda_pull(sda_pull));

  rtc_i2c_slave_port dut_u (.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .busy(busy));

  // ==========================================================
  // checking and closing
  task automatic check_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // a hang costs a mismatch; the whole run needs some 4200 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ==========================================================
  // scenarios
  // burst of three bytes from offset FE so the pointer wraps past FF
  task automatic t_write_burst();
    logic a;
    logic [7:0] wd [3] = '{8'hA5, 8'h5A, 8'h3C};
    m_u.start();
    m_u.wr_byte(8'hD2, a);
    check_bit("write address ack", 1'b1, a);
    m_u.wr_byte(8'hFE, a);
    check_bit("offset ack", 1'b1, a);
    for (int i = 0; i < 3; i++)
    begin
      m_u.wr_byte(wd[i], a);
      check_bit("data ack", 1'b1, a);
    end
    check_bit("busy in write", 1'b1, busy);
    m_u.stop();
    wait_cyc(10);
    check_bit("busy after stop", 1'b0, busy);
    check_byte("reg FE", 8'hA5, mem[8'hFE]);
    check_byte("reg FF", 8'h5A, mem[8'hFF]);
    check_byte("reg 00", 8'h3C, mem[8'h00]);
    $display("test write_burst done");
  endtask

  // offset write, restart, read three bytes, last one refused
  task automatic t_read_restart();
    logic a;
    logic [7:0] d;
    m_u.start();
    m_u.wr_byte(8'hD2, a);
    m_u.wr_byte(8'hFE, a);
    m_u.start();
    m_u.wr_byte(8'hD3, a);
    check_bit("read address ack", 1'b1, a);
    m_u.rd_byte(1'b1, d);
    check_byte("read 1", 8'hA5, d);
    m_u.rd_byte(1'b1, d);
    check_byte("read 2", 8'h5A, d);
    m_u.rd_byte(1'b0, d);
    check_byte("read 3", 8'h3C, d);
    // next register starts with a zero bit, so a stray send would pull
    wait_cyc(12);
    check_bit("released after nak", 1'b0, sda_oe);
    m_u.stop();
    wait_cyc(10);
    check_bit("idle after read", 1'b0, busy);
    $display("test read_restart done");
  endtask

  // read with no offset continues from the kept pointer; nak, restart, read on
  task automatic t_read_continue();
    logic a;
    logic [7:0] d;
    m_u.start();
    m_u.wr_byte(8'hD3, a);
    m_u.rd_byte(1'b0, d);
    check_byte("kept pointer", 8'h77, d);
    m_u.start();
    m_u.wr_byte(8'hD3, a);
    check_bit("restart ack", 1'b1, a);
    m_u.rd_byte(1'b0, d);
    check_byte("after restart", 8'h4B, d);
    m_u.stop();
    $display("test read_continue done");
  endtask

  // near misses in the top address bit, the two lowest address bits and the lowest one
  task automatic t_wrong_addr();
    logic a;
    logic [7:0] ad [3] = '{8'hD4, 8'hD0, 8'h52};
    for (int i = 0; i < 3; i++)
    begin
      m_u.start();
      m_u.wr_byte(ad[i], a);
      check_bit("foreign address nak", 1'b0, a);
      m_u.wr_byte(8'h00, a);
      check_bit("silent after miss", 1'b0, a);
      check_bit("not busy after miss", 1'b0, busy);
      m_u.stop();
    end
    $display("test wrong_addr done");
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    rst_b = 1'b0;
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 8'h00;
    end
    mem[8'h01] = 8'h77;
    mem[8'h02] = 8'h4B;
    wait_cyc(12);
    rst_b = 1'b1;
    wait_cyc(6);
    check_bit("data free after reset", 1'b0, sda_oe);
    check_bit("busy after reset", 1'b0, busy);
    t_write_burst();
    t_read_restart();
    t_read_continue();
    t_wrong_addr();
    report_and_stop();
  end
endmodule
